/* rtl/emsc_defines.svh */
// Purpose: constants for the statistics counter bank
// Assumes: byte offsets within the register window
// Notes: definitions only
`ifndef EMSC_DEFINES_SVH
`define EMSC_DEFINES_SVH

`define EMSC_IO_WIN_BYTES 10'h100
`define EMSC_MEM_WIN_BYTES 10'h200
`define EMSC_OFF_RX_GOOD_OCT 9'h0a8
`define EMSC_OFF_RX_GRP_OCT 9'h0ac
`define EMSC_OFF_RX_BC_OCT 9'h0b0
`define EMSC_OFF_RX_GOOD_FRM 9'h0b4
`define EMSC_OFF_RX_GRP_FRM 9'h0b8
`define EMSC_OFF_RX_BC_FRM 9'h0bc
`define EMSC_OFF_RX_PAUSE 9'h0c4
`define EMSC_OFF_RX_LEN_LONG 9'h0c8
`define EMSC_OFF_RX_LOSS_FCS 9'h0cc
`define EMSC_OFF_TX_GOOD_OCT 9'h0d0
`define EMSC_OFF_TX_GRP_OCT 9'h0d4
`define EMSC_OFF_TX_BC_OCT 9'h0d8
`define EMSC_OFF_TX_GOOD_FRM 9'h0dc
`define EMSC_OFF_TX_GRP_FRM 9'h0e0
`define EMSC_OFF_TX_DEFER 9'h0e4
`define EMSC_OFF_TX_LATE_COL 9'h0e8
`define EMSC_OFF_TX_MULTI_COL 9'h0ec
`define EMSC_OFF_TX_ONE_COL 9'h0f0
`define EMSC_OFF_TX_BC_FRM 9'h0f4
`define EMSC_OFF_TX_PAUSE_CRS 9'h0f8
`define EMSC_OFF_TX_XDEF_XCOL 9'h0fc
`define EMSC_VLAN_TAG_OCTETS 16'h0004
`define EMSC_NUM_CNT 25
`define EMSC_HALF_LO 1:0
`define EMSC_HI_SEL 1

`endif

/* rtl/emsc_pkg.sv */
// Purpose: shared types for the statistics counter bank
// Assumes: event indices match the counter order in emsc_stats_top
// Notes: types only
package emsc_pkg;
    typedef enum logic [4:0]
    {
        EMSC_RX_GOOD_OCT = 5'h00,
        EMSC_RX_GRP_OCT = 5'h01,
        EMSC_RX_BC_OCT = 5'h02,
        EMSC_RX_GOOD_FRM = 5'h03,
        EMSC_RX_GRP_FRM = 5'h04,
        EMSC_RX_BC_FRM = 5'h05,
        EMSC_RX_PAUSE = 5'h06,
        EMSC_RX_LEN_ERR = 5'h07,
        EMSC_RX_LONG_ERR = 5'h08,
        EMSC_RX_LOSS = 5'h09,
        EMSC_RX_FCS_ERR = 5'h0a,
        EMSC_TX_GOOD_OCT = 5'h0b,
        EMSC_TX_GRP_OCT = 5'h0c,
        EMSC_TX_BC_OCT = 5'h0d,
        EMSC_TX_GOOD_FRM = 5'h0e,
        EMSC_TX_GRP_FRM = 5'h0f,
        EMSC_TX_DEFER = 5'h10,
        EMSC_TX_LATE_COL = 5'h11,
        EMSC_TX_MULTI_COL = 5'h12,
        EMSC_TX_ONE_COL = 5'h13,
        EMSC_TX_BC_FRM = 5'h14,
        EMSC_TX_PAUSE = 5'h15,
        EMSC_TX_CRS_ERR = 5'h16,
        EMSC_TX_XDEFER = 5'h17,
        EMSC_TX_XCOL = 5'h18
    } emsc_cnt_idx_t;
endpackage : emsc_pkg

/* rtl/emsc_counter.sv */
// Purpose: one statistics counter with gating, wrap, threshold and host write
// Assumes: increment amount already filtered by the caller
// Notes: threshold is three quarters of full scale
`timescale 1ns/1ps
module emsc_counter #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // counting
    input wire logic count_en_i,
    input wire logic [W-1:0] inc_i,
    // host write
    input wire logic wr_i,
    input wire logic [W-1:0] wdata_i,
    // state
    output logic [W-1:0] count_o,
    output logic thresh_hit_o
);
    localparam logic [W-1:0] THRESH = {2'b11, {(W-2){1'b0}}};
    logic [W-1:0] sum_nxt;
    logic do_inc;

    assign do_inc = count_en_i && (inc_i != '0);
    // plain modular add: all ones plus one comes back to zero
    assign sum_nxt = count_o + inc_i;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            count_o <= '0;
        else if (wr_i)
            count_o <= wdata_i;
        else if (do_inc)
            count_o <= sum_nxt;
    end

    // pulse when an increment lands on or steps over the threshold
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            thresh_hit_o <= 1'b0;
        else
            thresh_hit_o <= !wr_i && do_inc && (count_o < THRESH) && (sum_nxt >= THRESH);
    end
endmodule : emsc_counter

/* rtl/emsc_stats_top.sv */
// Purpose: bank of Ethernet management statistics counters, host readable
// Assumes: one clock; frame events are one-cycle pulses from MAC paths
// Notes: windows decoded by the address bits below their size
// How it works
// - registers reachable through 256-byte io and 512-byte memory windows
// - counters follow 802.3 statistics and read as plain slave registers
// - rx broadcast frame counter counts good frames to all-ones address
// - errored, too long or overrun rx frames are not counted as broadcast
// - rx broadcast frame counter wraps to zero after all ones
// - rx broadcast frame counter sets update status at threshold
// - rx broadcast frame counter counts with enable set and mask clear
// - tx broadcast frame counter counts good frames sent to all-ones address
// - other multicast destinations do not count as tx broadcast
// - tx broadcast frame counter wraps to zero after all ones
// - tx broadcast frame counter sets update status at threshold
// - tx broadcast frame counter counts with enable set and mask clear
// - rx broadcast octet counter adds data and pad octets of broadcasts
// - octet counters add the four vlan tag octets when a tag was stripped or inserted
`timescale 1ns/1ps
`include "emsc_defines.svh"
module emsc_stats_top #(
    parameter int OCT_W = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // host slave access
    input wire logic io_sel_i,
    input wire logic mem_sel_i,
    input wire logic [8:0] addr_i,
    input wire logic [3:0] byte_en_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o,
    // control bits held elsewhere in the mac
    input wire logic stats_global_enable_i,
    input wire logic [24:0] stats_mask_register_i,
    // receive path frame report
    input wire logic rx_done_i,
    input wire logic rx_ok_i,
    input wire logic rx_too_long_i,
    input wire logic rx_fcs_err_i,
    input wire logic rx_len_err_i,
    input wire logic rx_align_err_i,
    input wire logic rx_overrun_i,
    input wire logic rx_bcast_i,
    input wire logic rx_mcast_i,
    input wire logic rx_pause_i,
    input wire logic [OCT_W-1:0] rx_octets_i,
    input wire logic rx_vlan_stripped_i,
    // transmit path frame report
    input wire logic tx_done_i,
    input wire logic tx_ok_i,
    input wire logic tx_bcast_i,
    input wire logic tx_mcast_i,
    input wire logic tx_pause_i,
    input wire logic tx_deferred_i,
    input wire logic tx_late_col_i,
    input wire logic tx_multi_col_i,
    input wire logic tx_one_col_i,
    input wire logic tx_crs_err_i,
    input wire logic tx_xdefer_i,
    input wire logic tx_xcol_i,
    input wire logic [OCT_W-1:0] tx_octets_i,
    input wire logic tx_vlan_inserted_i,
    // update status
    output logic stats_update_event_o
);
    localparam int N = `EMSC_NUM_CNT;

    ////////////////////////////////////////////////////////////////////////////
    // window decode
    logic in_win;
    logic acc_wr;
    logic acc_rd;
    logic [8:0] off;

    // io window only decodes the low 8 address bits
    assign off = io_sel_i ? {1'b0, addr_i[7:0]} : addr_i;
    assign in_win = io_sel_i || mem_sel_i;
    assign acc_wr = in_win && wr_i;
    assign acc_rd = in_win && rd_i;

    ////////////////////////////////////////////////////////////////////////////
    // event qualification
    logic rx_good;
    logic tx_good;
    logic [N-1:0] ev;
    logic [31:0] rx_oct_w;
    logic [31:0] tx_oct_w;

    assign rx_good = rx_done_i && rx_ok_i && !rx_too_long_i && !rx_fcs_err_i
                     && !rx_len_err_i && !rx_align_err_i && !rx_overrun_i;
    assign tx_good = tx_done_i && tx_ok_i;
    // stripped or inserted tags are added back in
    assign rx_oct_w = 32'(rx_octets_i)
                      + (rx_vlan_stripped_i ? 32'(`EMSC_VLAN_TAG_OCTETS) : 32'h0);
    assign tx_oct_w = 32'(tx_octets_i)
                      + (tx_vlan_inserted_i ? 32'(`EMSC_VLAN_TAG_OCTETS) : 32'h0);

    always_comb
    begin
        ev = '0;
        ev[emsc_pkg::EMSC_RX_GOOD_OCT] = rx_good;
        ev[emsc_pkg::EMSC_RX_GRP_OCT] = rx_good && rx_mcast_i;
        ev[emsc_pkg::EMSC_RX_BC_OCT] = rx_good && rx_bcast_i;
        ev[emsc_pkg::EMSC_RX_GOOD_FRM] = rx_good;
        ev[emsc_pkg::EMSC_RX_GRP_FRM] = rx_good && rx_mcast_i;
        ev[emsc_pkg::EMSC_RX_BC_FRM] = rx_good && rx_bcast_i;
        ev[emsc_pkg::EMSC_RX_PAUSE] = rx_good && rx_pause_i;
        ev[emsc_pkg::EMSC_RX_LEN_ERR] = rx_done_i && rx_len_err_i;
        ev[emsc_pkg::EMSC_RX_LONG_ERR] = rx_done_i && rx_too_long_i;
        ev[emsc_pkg::EMSC_RX_LOSS] = rx_done_i && rx_overrun_i;
        ev[emsc_pkg::EMSC_RX_FCS_ERR] = rx_done_i && rx_fcs_err_i;
        ev[emsc_pkg::EMSC_TX_GOOD_OCT] = tx_good;
        ev[emsc_pkg::EMSC_TX_GRP_OCT] = tx_good && tx_mcast_i && !tx_bcast_i;
        ev[emsc_pkg::EMSC_TX_BC_OCT] = tx_good && tx_bcast_i;
        ev[emsc_pkg::EMSC_TX_GOOD_FRM] = tx_good;
        ev[emsc_pkg::EMSC_TX_GRP_FRM] = tx_good && tx_mcast_i && !tx_bcast_i;
        ev[emsc_pkg::EMSC_TX_DEFER] = tx_good && tx_deferred_i;
        ev[emsc_pkg::EMSC_TX_LATE_COL] = tx_done_i && tx_late_col_i;
        ev[emsc_pkg::EMSC_TX_MULTI_COL] = tx_good && tx_multi_col_i;
        ev[emsc_pkg::EMSC_TX_ONE_COL] = tx_good && tx_one_col_i;
        // the bcast flag alone, never the group flag
        ev[emsc_pkg::EMSC_TX_BC_FRM] = tx_good && tx_bcast_i;
        ev[emsc_pkg::EMSC_TX_PAUSE] = tx_good && tx_pause_i;
        ev[emsc_pkg::EMSC_TX_CRS_ERR] = tx_done_i && tx_crs_err_i;
        ev[emsc_pkg::EMSC_TX_XDEFER] = tx_done_i && tx_xdefer_i;
        ev[emsc_pkg::EMSC_TX_XCOL] = tx_done_i && tx_xcol_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters
    logic [N-1:0] gate;
    logic [N-1:0] hit;
    logic [N-1:0] wsel;
    logic [31:0] cnt [N];

    // enable set and own mask bit clear
    assign gate = {N{stats_global_enable_i}} & ~stats_mask_register_i;

    // write strobes: wide regs need all lanes, halves their own pair
    always_comb
    begin
        wsel = '0;
        if (acc_wr)
        begin
            if (off == `EMSC_OFF_RX_GOOD_OCT)
                wsel[emsc_pkg::EMSC_RX_GOOD_OCT] = &byte_en_i;
            else if (off == `EMSC_OFF_RX_GRP_OCT)
                wsel[emsc_pkg::EMSC_RX_GRP_OCT] = &byte_en_i;
            else if (off == `EMSC_OFF_RX_BC_OCT)
                wsel[emsc_pkg::EMSC_RX_BC_OCT] = &byte_en_i;
            else if (off == `EMSC_OFF_RX_GOOD_FRM)
                wsel[emsc_pkg::EMSC_RX_GOOD_FRM] = &byte_en_i;
            else if (off == `EMSC_OFF_RX_GRP_FRM)
                wsel[emsc_pkg::EMSC_RX_GRP_FRM] = &byte_en_i;
            else if (off == `EMSC_OFF_RX_BC_FRM)
                wsel[emsc_pkg::EMSC_RX_BC_FRM] = &byte_en_i[3:2];
            else if (off == `EMSC_OFF_RX_PAUSE)
                wsel[emsc_pkg::EMSC_RX_PAUSE] = &byte_en_i[3:2];
            else if (off == `EMSC_OFF_RX_LEN_LONG)
            begin
                wsel[emsc_pkg::EMSC_RX_LEN_ERR] = &byte_en_i[3:2];
                wsel[emsc_pkg::EMSC_RX_LONG_ERR] = &byte_en_i[`EMSC_HALF_LO];
            end
            else if (off == `EMSC_OFF_RX_LOSS_FCS)
            begin
                wsel[emsc_pkg::EMSC_RX_LOSS] = &byte_en_i[3:2];
                wsel[emsc_pkg::EMSC_RX_FCS_ERR] = &byte_en_i[`EMSC_HALF_LO];
            end
            else if (off == `EMSC_OFF_TX_GOOD_OCT)
                wsel[emsc_pkg::EMSC_TX_GOOD_OCT] = &byte_en_i;
            else if (off == `EMSC_OFF_TX_GRP_OCT)
                wsel[emsc_pkg::EMSC_TX_GRP_OCT] = &byte_en_i;
            else if (off == `EMSC_OFF_TX_BC_OCT)
                wsel[emsc_pkg::EMSC_TX_BC_OCT] = &byte_en_i;
            else if (off == `EMSC_OFF_TX_GOOD_FRM)
                wsel[emsc_pkg::EMSC_TX_GOOD_FRM] = &byte_en_i;
            else if (off == `EMSC_OFF_TX_GRP_FRM)
                wsel[emsc_pkg::EMSC_TX_GRP_FRM] = &byte_en_i;
            else if (off == `EMSC_OFF_TX_DEFER)
                wsel[emsc_pkg::EMSC_TX_DEFER] = &byte_en_i;
            else if (off == `EMSC_OFF_TX_LATE_COL)
                wsel[emsc_pkg::EMSC_TX_LATE_COL] = &byte_en_i;
            else if (off == `EMSC_OFF_TX_MULTI_COL)
                wsel[emsc_pkg::EMSC_TX_MULTI_COL] = &byte_en_i;
            else if (off == `EMSC_OFF_TX_ONE_COL)
                wsel[emsc_pkg::EMSC_TX_ONE_COL] = &byte_en_i;
            else if (off == `EMSC_OFF_TX_BC_FRM)
                wsel[emsc_pkg::EMSC_TX_BC_FRM] = &byte_en_i[3:2];
            else if (off == `EMSC_OFF_TX_PAUSE_CRS)
            begin
                wsel[emsc_pkg::EMSC_TX_PAUSE] = &byte_en_i[3:2];
                wsel[emsc_pkg::EMSC_TX_CRS_ERR] = &byte_en_i[`EMSC_HALF_LO];
            end
            else if (off == `EMSC_OFF_TX_XDEF_XCOL)
            begin
                wsel[emsc_pkg::EMSC_TX_XDEFER] = &byte_en_i[3:2];
                wsel[emsc_pkg::EMSC_TX_XCOL] = &byte_en_i[`EMSC_HALF_LO];
            end
        end
    end

    // which counters are 32 bits wide
    localparam logic [N-1:0] WIDE = 25'h00ff81f;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_cnt
            logic [31:0] inc;
            if (gi == int'(emsc_pkg::EMSC_RX_GOOD_OCT) || gi == int'(emsc_pkg::EMSC_RX_GRP_OCT)
                || gi == int'(emsc_pkg::EMSC_RX_BC_OCT))
            begin : g_rxo
                assign inc = ev[gi] ? rx_oct_w : 32'h0;
            end
            else if (gi == int'(emsc_pkg::EMSC_TX_GOOD_OCT) || gi == int'(emsc_pkg::EMSC_TX_GRP_OCT)
                     || gi == int'(emsc_pkg::EMSC_TX_BC_OCT))
            begin : g_txo
                assign inc = ev[gi] ? tx_oct_w : 32'h0;
            end
            else
            begin : g_frm
                assign inc = {31'h0, ev[gi]};
            end
            if (WIDE[gi])
            begin : g_w
                emsc_counter #(.W(32)) u_cnt (
                    .mclk_i(mclk_i),
                    .srst_i(srst_i),
                    .count_en_i(gate[gi]),
                    .inc_i(inc),
                    .wr_i(wsel[gi]),
                    .wdata_i(wdata_i),
                    .count_o(cnt[gi]),
                    .thresh_hit_o(hit[gi])
                );
            end
            else
            begin : g_n
                logic [15:0] c16;
                // upper register of a shared word sits in the high lanes
                logic [15:0] wd16;
                assign wd16 = (gi == int'(emsc_pkg::EMSC_RX_LONG_ERR)
                               || gi == int'(emsc_pkg::EMSC_RX_FCS_ERR)
                               || gi == int'(emsc_pkg::EMSC_TX_CRS_ERR)
                               || gi == int'(emsc_pkg::EMSC_TX_XCOL))
                              ? wdata_i[15:0] : wdata_i[31:16];
                emsc_counter #(.W(16)) u_cnt (
                    .mclk_i(mclk_i),
                    .srst_i(srst_i),
                    .count_en_i(gate[gi]),
                    .inc_i(inc[15:0]),
                    .wr_i(wsel[gi]),
                    .wdata_i(wd16),
                    .count_o(c16),
                    .thresh_hit_o(hit[gi])
                );
                assign cnt[gi] = {16'h0, c16};
            end
        end
    endgenerate

    assign stats_update_event_o = |hit;

    ////////////////////////////////////////////////////////////////////////////
    // read path
    logic [31:0] rd_nxt;

    // 16-bit registers sit in bytes 4 and 3 of their word, the lower one of a shared pair in bytes 2 and 1
    always_comb
    begin
        rd_nxt = 32'h0;
        if (off == `EMSC_OFF_RX_GOOD_OCT)
            rd_nxt = cnt[emsc_pkg::EMSC_RX_GOOD_OCT];
        else if (off == `EMSC_OFF_RX_GRP_OCT)
            rd_nxt = cnt[emsc_pkg::EMSC_RX_GRP_OCT];
        else if (off == `EMSC_OFF_RX_BC_OCT)
            rd_nxt = cnt[emsc_pkg::EMSC_RX_BC_OCT];
        else if (off == `EMSC_OFF_RX_GOOD_FRM)
            rd_nxt = cnt[emsc_pkg::EMSC_RX_GOOD_FRM];
        else if (off == `EMSC_OFF_RX_GRP_FRM)
            rd_nxt = cnt[emsc_pkg::EMSC_RX_GRP_FRM];
        else if (off == `EMSC_OFF_RX_BC_FRM)
            rd_nxt = {cnt[emsc_pkg::EMSC_RX_BC_FRM][15:0], 16'h0};
        else if (off == `EMSC_OFF_RX_PAUSE)
            rd_nxt = {cnt[emsc_pkg::EMSC_RX_PAUSE][15:0], 16'h0};
        else if (off == `EMSC_OFF_RX_LEN_LONG)
            rd_nxt = {cnt[emsc_pkg::EMSC_RX_LEN_ERR][15:0], cnt[emsc_pkg::EMSC_RX_LONG_ERR][15:0]};
        else if (off == `EMSC_OFF_RX_LOSS_FCS)
            rd_nxt = {cnt[emsc_pkg::EMSC_RX_LOSS][15:0], cnt[emsc_pkg::EMSC_RX_FCS_ERR][15:0]};
        else if (off == `EMSC_OFF_TX_GOOD_OCT)
            rd_nxt = cnt[emsc_pkg::EMSC_TX_GOOD_OCT];
        else if (off == `EMSC_OFF_TX_GRP_OCT)
            rd_nxt = cnt[emsc_pkg::EMSC_TX_GRP_OCT];
        else if (off == `EMSC_OFF_TX_BC_OCT)
            rd_nxt = cnt[emsc_pkg::EMSC_TX_BC_OCT];
        else if (off == `EMSC_OFF_TX_GOOD_FRM)
            rd_nxt = cnt[emsc_pkg::EMSC_TX_GOOD_FRM];
        else if (off == `EMSC_OFF_TX_GRP_FRM)
            rd_nxt = cnt[emsc_pkg::EMSC_TX_GRP_FRM];
        else if (off == `EMSC_OFF_TX_DEFER)
            rd_nxt = cnt[emsc_pkg::EMSC_TX_DEFER];
        else if (off == `EMSC_OFF_TX_LATE_COL)
            rd_nxt = cnt[emsc_pkg::EMSC_TX_LATE_COL];
        else if (off == `EMSC_OFF_TX_MULTI_COL)
            rd_nxt = cnt[emsc_pkg::EMSC_TX_MULTI_COL];
        else if (off == `EMSC_OFF_TX_ONE_COL)
            rd_nxt = cnt[emsc_pkg::EMSC_TX_ONE_COL];
        else if (off == `EMSC_OFF_TX_BC_FRM)
            rd_nxt = {cnt[emsc_pkg::EMSC_TX_BC_FRM][15:0], 16'h0};
        else if (off == `EMSC_OFF_TX_PAUSE_CRS)
            rd_nxt = {cnt[emsc_pkg::EMSC_TX_PAUSE][15:0], cnt[emsc_pkg::EMSC_TX_CRS_ERR][15:0]};
        else if (off == `EMSC_OFF_TX_XDEF_XCOL)
            rd_nxt = {cnt[emsc_pkg::EMSC_TX_XDEFER][15:0], cnt[emsc_pkg::EMSC_TX_XCOL][15:0]};
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            rdata_o <= 32'h0;
            rvalid_o <= 1'b0;
        end
        else
        begin
            rdata_o <= acc_rd ? rd_nxt : 32'h0;
            rvalid_o <= acc_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_bcast_rx_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
        (!stats_global_enable_i || stats_mask_register_i[5]) && !wsel[5]
        |=> $stable(cnt[5])) else $error("rx bcast counted while gated");
    a_bcast_rx_inc: assert property (@(posedge mclk_i) disable iff (srst_i)
        rx_good && rx_bcast_i && gate[5] && !wsel[5]
        |=> cnt[5][15:0] == 16'($past(cnt[5][15:0]) + 16'h1))
        else $error("rx bcast did not step");
    a_bcast_rx_err: assert property (@(posedge mclk_i) disable iff (srst_i)
        rx_done_i && rx_fcs_err_i && !wsel[5] |=> $stable(cnt[5]))
        else $error("errored frame counted");
    a_bcast_tx_inc: assert property (@(posedge mclk_i) disable iff (srst_i)
        tx_good && tx_bcast_i && gate[20] && !wsel[20]
        |=> cnt[20][15:0] == 16'($past(cnt[20][15:0]) + 16'h1))
        else $error("tx bcast did not step");
    a_bcast_tx_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
        (!stats_global_enable_i || stats_mask_register_i[20]) && !wsel[20]
        |=> $stable(cnt[20])) else $error("tx bcast counted while gated");
    a_mcast_tx_excl: assert property (@(posedge mclk_i) disable iff (srst_i)
        tx_good && !tx_bcast_i && !wsel[20] |=> $stable(cnt[20]))
        else $error("tx multicast counted as bcast");
    a_thresh_rx_frm: assert property (@(posedge mclk_i) disable iff (srst_i)
        cnt[5] == 32'h0000bfff && ev[5] && gate[5] && !wsel[5]
        |=> stats_update_event_o) else $error("rx threshold missed");
    a_thresh_tx_frm: assert property (@(posedge mclk_i) disable iff (srst_i)
        cnt[20] == 32'h0000bfff && ev[20] && gate[20] && !wsel[20]
        |=> stats_update_event_o) else $error("tx threshold missed");
    a_oct_rx_add: assert property (@(posedge mclk_i) disable iff (srst_i)
        ev[2] && gate[2] && !wsel[2] |=> cnt[2] == $past(cnt[2]) + $past(rx_oct_w))
        else $error("rx bcast octets wrong");
    a_read_lat: assert property (@(posedge mclk_i) disable iff (srst_i)
        acc_rd |=> rvalid_o ##1 !rvalid_o || $past(acc_rd))
        else $error("read answer timing");
endmodule : emsc_stats_top

/* verification/emsc_host_model.sv */
// Purpose: host side model issuing slave register accesses
// Assumes: one access at a time, started by the bench
// Notes: signals change on falling edges only
`timescale 1ns/1ps
module emsc_host_model (
    // clock
    input wire logic mclk_i,
    // slave access
    output logic io_sel_o,
    output logic mem_sel_o,
    output logic [8:0] addr_o,
    output logic [3:0] byte_en_o,
    output logic wr_o,
    output logic rd_o,
    output logic [31:0] wdata_o,
    // answer
    input wire logic [31:0] rdata_i,
    input wire logic rvalid_i
);
    initial
    begin
        {io_sel_o, mem_sel_o, wr_o, rd_o} = 4'h0;
        addr_o = 9'h000;
        byte_en_o = 4'h0;
        wdata_o = 32'h0;
    end
    ////////////////////////////////////////
    // lanes driven exactly as the caller gives them
    task automatic acc(input logic io, input logic w, input logic [8:0] a,
        input logic [3:0] be, input logic [31:0] d, output logic [31:0] q);
        @(negedge mclk_i);
        io_sel_o = io;
        mem_sel_o = !io;
        addr_o = a;
        byte_en_o = be;
        wr_o = w;
        rd_o = !w;
        wdata_o = d;
        @(negedge mclk_i);
        q = (rvalid_i === 1'b1) ? rdata_i : 32'hx;
        {io_sel_o, mem_sel_o, wr_o, rd_o} = 4'h0;
        // stale data would hide a missed write strobe
        wdata_o = ~d;
    endtask : acc
endmodule : emsc_host_model

/* verification/testbench.sv */
// Purpose: self-checking bench for the statistics counter bank
// Assumes: host model drives the slave port
// Notes: expected counts follow from the frames sent here
`timescale 1ns/1ps
module testbench;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic en = 1'b1;
    logic [24:0] msk = 25'h0;
    logic rx_done = 1'b0;
    logic tx_done = 1'b0;
    logic [9:0] rq = 10'h0;
    logic [11:0] tq = 12'h0;
    logic [15:0] oct = 16'h0;
    logic io_sel, mem_sel, wr, rd, rvalid, upd;
    logic [8:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata, q;
    int n_errors = 0;
    int checks = 0;
    int n_upd = 0;
    always #25 mclk_i = ~mclk_i;
    // sampled mid-cycle, well away from the edge that launches the pulse
    always @(negedge mclk_i)
        if (upd === 1'b1)
            n_upd <= n_upd + 1;
    emsc_stats_top u_dut (
        .mclk_i(mclk_i), .srst_i(srst_i), .io_sel_i(io_sel), .mem_sel_i(mem_sel),
        .addr_i(addr), .byte_en_i(be), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
        .rdata_o(rdata), .rvalid_o(rvalid), .stats_global_enable_i(en),
        .stats_mask_register_i(msk), .rx_done_i(rx_done), .rx_ok_i(rq[9]),
        .rx_too_long_i(rq[8]), .rx_fcs_err_i(rq[7]), .rx_len_err_i(rq[6]),
        .rx_align_err_i(rq[5]), .rx_overrun_i(rq[4]), .rx_bcast_i(rq[3]),
        .rx_mcast_i(rq[2]), .rx_pause_i(rq[1]), .rx_octets_i(oct),
        .rx_vlan_stripped_i(rq[0]), .tx_done_i(tx_done), .tx_ok_i(tq[11]),
        .tx_bcast_i(tq[10]), .tx_mcast_i(tq[9]), .tx_pause_i(tq[8]),
        .tx_deferred_i(tq[7]), .tx_late_col_i(tq[6]), .tx_multi_col_i(tq[5]),
        .tx_one_col_i(tq[4]), .tx_crs_err_i(tq[3]), .tx_xdefer_i(tq[2]),
        .tx_xcol_i(tq[1]), .tx_octets_i(oct), .tx_vlan_inserted_i(tq[0]),
        .stats_update_event_o(upd));
    emsc_host_model u_host (
        .mclk_i(mclk_i), .io_sel_o(io_sel), .mem_sel_o(mem_sel), .addr_o(addr),
        .byte_en_o(be), .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata),
        .rvalid_i(rvalid));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // one frame report, qualifiers held for the done cycle only
    task automatic frm(input logic tx, input logic [11:0] f, input logic [15:0] n);
        @(negedge mclk_i);
        tx_done = tx;
        rx_done = !tx;
        tq = tx ? f : 12'h0;
        rq = tx ? 10'h0 : f[9:0];
        oct = n;
        @(negedge mclk_i);
        {tx_done, rx_done, tq, rq} = 24'h0;
        @(negedge mclk_i);
    endtask : frm
    task automatic rdc(input logic io, input logic [8:0] a, input logic [3:0] b,
        input logic [31:0] e, input string m);
        u_host.acc(io, 1'b0, a, b, 32'h0, q);
        chk(q, e, m);
    endtask : rdc
    ////////////////////////////////////////
    task automatic t_basic;
        rdc(1'b1, 9'h0bc, 4'hc, 32'h0, "reset value");
        frm(1'b0, 12'h209, 16'd64);
        rdc(1'b1, 9'h0bc, 4'hc, 32'h0001_0000, "rx bcast frame");
        rdc(1'b0, 9'h0b0, 4'hf, 32'd68, "rx bcast octets mem");
        rdc(1'b1, 9'h1b0, 4'hf, 32'd68, "rx bcast octets io");
        rdc(1'b1, 9'h0b4, 4'hf, 32'd1, "rx good frames");
        rdc(1'b1, 9'h0c0, 4'hf, 32'h0, "unmapped offset");
    endtask : t_basic
    task automatic t_err;
        for (int i = 4; i <= 8; i++)
            frm(1'b0, 12'h208 | (12'h1 << i), 16'd64);
        rdc(1'b1, 9'h0bc, 4'hc, 32'h0001_0000, "errored bcast");
        rdc(1'b1, 9'h0cc, 4'hf, 32'h0001_0001, "rx loss and fcs");
    endtask : t_err
    task automatic t_gate;
        en = 1'b0;
        frm(1'b0, 12'h208, 16'd64);
        en = 1'b1;
        msk[emsc_pkg::EMSC_RX_BC_FRM] = 1'b1;
        msk[emsc_pkg::EMSC_TX_BC_FRM] = 1'b1;
        frm(1'b0, 12'h208, 16'd64);
        frm(1'b1, 12'hc00, 16'd64);
        msk = 25'h0;
        rdc(1'b1, 9'h0bc, 4'hc, 32'h0001_0000, "rx gated");
        rdc(1'b1, 9'h0f4, 4'hc, 32'h0, "tx gated");
    endtask : t_gate
    task automatic t_tx;
        frm(1'b1, 12'hc00, 16'd64);
        frm(1'b1, 12'ha00, 16'd64);
        rdc(1'b0, 9'h0f4, 4'hc, 32'h0001_0000, "tx bcast not mcast");
        rdc(1'b0, 9'h0dc, 4'hf, 32'd3, "tx good frames");
        u_host.acc(1'b0, 1'b1, 9'h0dc, 4'hf, 32'h1234_5678, q);
        rdc(1'b0, 9'h0dc, 4'hf, 32'h1234_5678, "tx good frame write");
    endtask : t_tx
    task automatic t_wrap;
        logic [8:0] wa [2] = '{9'h0bc, 9'h0f4};
        logic [11:0] wf [2] = '{12'h208, 12'hc00};
        int u;
        for (int i = 0; i < 2; i++)
        begin
            u_host.acc(1'b1, 1'b1, wa[i], 4'hc, 32'hbfff_0000, q);
            u = n_upd;
            frm(i[0], wf[i], 16'd64);
            chk(32'(n_upd - u), 32'h1, "threshold pulse");
            rdc(1'b1, wa[i], 4'hc, 32'hc000_0000, "at threshold");
            u_host.acc(1'b1, 1'b1, wa[i], 4'hc, 32'hffff_0000, q);
            frm(i[0], wf[i], 16'd64);
            rdc(1'b1, wa[i], 4'hc, 32'h0, "wrap to zero");
        end
        u_host.acc(1'b0, 1'b1, 9'h0b0, 4'hf, 32'hbfff_ffc0, q);
        u = n_upd;
        frm(1'b0, 12'h208, 16'd64);
        chk(32'(n_upd - u), 32'h1, "octet threshold pulse");
        rdc(1'b1, 9'h0b0, 4'hf, 32'hc000_0000, "octet threshold");
    endtask : t_wrap
    ////////////////////////////////////////
    initial
    begin
        repeat (10) @(negedge mclk_i);
        srst_i = 1'b0;
        t_basic();
        t_err();
        t_gate();
        t_tx();
        t_wrap();
        end_sim();
    end
    // whole run is about a hundred cycles
    initial
    begin
        #100000;
        n_errors++;
        end_sim();
    end
endmodule : testbench
